/* File: pkg/pll_synth_defines.svh */
// Constants for the parallel PLL synthesizer core
`ifndef PLL_SYNTH_DEFINES_SVH
`define PLL_SYNTH_DEFINES_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PLL_REF_W          14
`define PLL_FBV_W          14
`define PLL_FBC_W          15

// ----------------------------------------------------------------
// Reference divide ratios, one per select code
// ----------------------------------------------------------------
`define PLL_REF_RATIO_0    14'h0008
`define PLL_REF_RATIO_1    14'h0080
`define PLL_REF_RATIO_2    14'h0100
`define PLL_REF_RATIO_3    14'h0200
`define PLL_REF_RATIO_4    14'h0400
`define PLL_REF_RATIO_5    14'h0800
`define PLL_REF_RATIO_6    14'h096A
`define PLL_REF_RATIO_7    14'h2000

// ----------------------------------------------------------------
// Feedback offset and reset values
// ----------------------------------------------------------------
`define PLL_TR_OFFSET      15'h0358
`define PLL_FBC_RESET      15'h0000
`define PLL_REFC_RESET     14'h0000

`endif

/* File: pkg/pll_synth_pkg.sv */
// Types shared by the synthesizer core files
package pll_synth_pkg;
   typedef logic [2:0]  ref_sel_t;
   typedef logic [13:0] fb_value_t;
   typedef logic [13:0] ref_count_t;
   typedef logic [14:0] fb_count_t;
endpackage

/* File: rtl/pll_synth_core.sv */
// Digital core of a parallel-programmed PLL frequency synthesizer
//
// Functional notes
// - Reference divided by 8,128,256,512,1024,2048,2410 or 8192 per 3-bit select.
// - Feedback divider reloads parallel 14-bit value on the tick at a count of one; bit 0 is LSB.
// - Offset select low adds 856 to feedback value; high adds nothing.
// - Three-state output pulses negative when feedback is faster or leading.
// - Three-state output pulses positive when feedback is slower or lagging.
// - Three-state output floats when frequency and phase coincide.
// - Feedback faster or leading: feedback-side output low, reference-side high.
// - Feedback slower or lagging: reference-side output low, feedback-side high.
// - In lock both double-ended outputs pulse low together briefly each cycle.
// - Feedback divider output is driven buffered on its own pin.
// - Lock indicator high when locked, pulses low while out of lock.
`timescale 1ns/1ps
`include "pll_synth_defines.svh"

module pll_synth_core (
   // Clock and reset
   input  wire logic                      CLK_IN,
   input  wire logic                      RST_B_IN,
   // Loop and reference inputs
   input  wire logic                      FEEDBACK_IN,
   input  wire logic                      REF_OSC_INPUT_IN,
   // Static programming
   input  wire pll_synth_pkg::ref_sel_t   REF_DIV_SELECT_IN,
   input  wire pll_synth_pkg::fb_value_t  FEEDBACK_DIV_VALUE_IN,
   input  wire logic                      TR_OFFSET_SELECT_IN,
   // Single-ended three-state detector output
   output logic                           TRISTATE_PHASE_ERROR_OUT,
   output logic                           TRISTATE_PHASE_ERROR_OE_OUT,
   // Double-ended detector outputs, active low
   output logic                           PHASE_REF_B_OUT,
   output logic                           PHASE_FB_B_OUT,
   // Divider and lock outputs
   output logic                           FEEDBACK_DIV_OUT,
   output logic                           LOCK_INDICATOR_OUT
);
   import pll_synth_pkg::*;

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   // Two flops so release is clean to the clock
   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Input edge detection
   // ----------------------------------------------------------------
   logic fb_in_q;
   logic ref_in_q;
   logic fb_tick;
   logic ref_tick;

   // Inputs are synchronous; source rates must not exceed half of CLK_IN
   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fb_in_q  <= 1'b0;
         ref_in_q <= 1'b0;
      end else begin
         fb_in_q  <= FEEDBACK_IN;
         ref_in_q <= REF_OSC_INPUT_IN;
      end
   end

   assign fb_tick  = FEEDBACK_IN && !fb_in_q;
   assign ref_tick = REF_OSC_INPUT_IN && !ref_in_q;

   // ----------------------------------------------------------------
   // Divide values
   // ----------------------------------------------------------------
   ref_count_t ref_ratio;
   fb_count_t  fb_value;

   always_comb begin
      case (REF_DIV_SELECT_IN)
         3'h0:    ref_ratio = `PLL_REF_RATIO_0;
         3'h1:    ref_ratio = `PLL_REF_RATIO_1;
         3'h2:    ref_ratio = `PLL_REF_RATIO_2;
         3'h3:    ref_ratio = `PLL_REF_RATIO_3;
         3'h4:    ref_ratio = `PLL_REF_RATIO_4;
         3'h5:    ref_ratio = `PLL_REF_RATIO_5;
         3'h6:    ref_ratio = `PLL_REF_RATIO_6;
         default: ref_ratio = `PLL_REF_RATIO_7;
      endcase
   end

   // offset adder
   // Extra bit keeps the largest sum from wrapping
   assign fb_value = {1'b0, FEEDBACK_DIV_VALUE_IN}
                     + (TR_OFFSET_SELECT_IN ? 15'h0000 : `PLL_TR_OFFSET);

   // ----------------------------------------------------------------
   // Dividers
   // ----------------------------------------------------------------
   logic ref_pulse;
   logic fb_pulse;
   logic fb_level;

   prog_divider #(
      .W (`PLL_REF_W)
   ) u_ref_div (
      .clk_in    (CLK_IN),
      .rst_n_in  (rst_n_q),
      .tick_in   (ref_tick),
      .load_in   (ref_ratio),
      .pulse_out (ref_pulse),
      .level_out ()
   );

   // values below 2 are not guarded; such a ratio divides by one
   prog_divider #(
      .W (`PLL_FBC_W)
   ) u_fb_div (
      .clk_in    (CLK_IN),
      .rst_n_in  (rst_n_q),
      .tick_in   (fb_tick),
      .load_in   (fb_value),
      .pulse_out (fb_pulse),
      .level_out (fb_level)
   );

   assign FEEDBACK_DIV_OUT = fb_level;

   // ----------------------------------------------------------------
   // Phase/frequency detector
   // ----------------------------------------------------------------
   logic up_q;
   logic dn_q;
   logic up_d;
   logic dn_d;

   // compare both divider outputs
   // Both set means coincidence; clearing after one cycle gives the
   // short common low pulse, and a new edge in that cycle still sets
   always_comb begin
      up_d = (up_q && !dn_q) || ref_pulse;
      dn_d = (dn_q && !up_q) || fb_pulse;
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         up_q <= up_d;
         dn_q <= dn_d;
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         TRISTATE_PHASE_ERROR_OUT    <= 1'b0;
         TRISTATE_PHASE_ERROR_OE_OUT <= 1'b0;
      end else begin
         TRISTATE_PHASE_ERROR_OUT    <= up_d && !dn_d;
         TRISTATE_PHASE_ERROR_OE_OUT <= up_d ^ dn_d;
      end
   end

   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         PHASE_REF_B_OUT <= 1'b1;
         PHASE_FB_B_OUT  <= 1'b1;
      end else begin
         PHASE_REF_B_OUT <= !up_d;
         PHASE_FB_B_OUT  <= !dn_d;
      end
   end

   // lock indicator
   // Common coincidence pulse is not an error, so lock stays high then
   always_ff @(posedge CLK_IN or negedge rst_n_q) begin
      if (!rst_n_q) begin
         LOCK_INDICATOR_OUT <= 1'b1;
      end else begin
         LOCK_INDICATOR_OUT <= !(up_d ^ dn_d);
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic idle;
   assign idle = !up_q && !dn_q;

   ref_ratio_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      REF_DIV_SELECT_IN == 3'h6 |-> ref_ratio == 14'h096A)
      else $error("reference ratio wrong for code six");

   offset_add_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      !TR_OFFSET_SELECT_IN |-> fb_value == {1'b0, FEEDBACK_DIV_VALUE_IN} + 15'h0358)
      else $error("offset not added while select low");

   neg_pulse_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      idle && fb_pulse && !ref_pulse |=> TRISTATE_PHASE_ERROR_OE_OUT
                                          && !TRISTATE_PHASE_ERROR_OUT)
      else $error("no negative pulse on leading feedback");

   pos_pulse_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      idle && ref_pulse && !fb_pulse |=> TRISTATE_PHASE_ERROR_OE_OUT
                                          && TRISTATE_PHASE_ERROR_OUT)
      else $error("no positive pulse on lagging feedback");

   hiz_coincide_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      idle && ref_pulse && fb_pulse |=> !TRISTATE_PHASE_ERROR_OE_OUT [*2])
      else $error("three-state output driven at coincidence");

   fb_side_low_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      idle && fb_pulse && !ref_pulse |=> !PHASE_FB_B_OUT && PHASE_REF_B_OUT)
      else $error("feedback-side output not low on leading feedback");

   ref_side_low_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      idle && ref_pulse && !fb_pulse |=> !PHASE_REF_B_OUT && PHASE_FB_B_OUT)
      else $error("reference-side output not low on lagging feedback");

   both_pulse_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      idle && ref_pulse && fb_pulse |=> (!PHASE_REF_B_OUT && !PHASE_FB_B_OUT)
                                        ##1 (PHASE_REF_B_OUT && PHASE_FB_B_OUT))
      else $error("coincidence pulse not one cycle on both outputs");

   fb_buffer_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      $rose(FEEDBACK_DIV_OUT) |-> $past(fb_pulse, 1) == 1'b0 && fb_pulse)
      else $error("buffered output not aligned with detector pulse");

   lock_low_a : assert property (@(posedge CLK_IN) disable iff (!rst_n_q)
      idle && (ref_pulse != fb_pulse) |=> !LOCK_INDICATOR_OUT)
      else $error("lock indicator high during one-sided error");

endmodule

/* File: rtl/prog_divider.sv */
// Programmable divide-by-value counter with reload at terminal count
`timescale 1ns/1ps
`include "pll_synth_defines.svh"

module prog_divider #(
   parameter int W = 14
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   // Count source and ratio
   input  wire logic         tick_in,
   input  wire logic [W-1:0] load_in,
   // Divided outputs
   output logic              pulse_out,
   output logic              level_out
);

   logic [W-1:0] cnt_q;
   logic         term;

   // Last tick of a full count cycle
   assign term = tick_in && (cnt_q <= W'(1));

   // reload from inputs
   // Reload picks up the inputs live, so a change takes effect at the next terminal count
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q <= '0;
      end else if (term) begin
         cnt_q <= load_in;
      end else if (tick_in) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pulse_out <= 1'b0;
      end else begin
         pulse_out <= term;
      end
   end

   // Level high for one source period after terminal count
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level_out <= 1'b0;
      end else if (tick_in) begin
         level_out <= term;
      end
   end

   reload_value_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      term |=> cnt_q == $past(load_in))
      else $error("divider did not reload programmed value");

   term_pulse_a : assert property (@(posedge clk_in) disable iff (!rst_n_in)
      tick_in && cnt_q > W'(1) |=> !pulse_out && cnt_q == $past(cnt_q) - W'(1))
      else $error("divider pulsed or miscounted before terminal count");

endmodule

/* File: testbench/parallel_pll_synth_core_tb.sv */
// Self-checking bench for the parallel PLL synthesizer core
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD t=%0t %s", $time, msg); end end

module parallel_pll_synth_core_tb;
   import pll_synth_pkg::*;
   typedef struct {ref_sel_t sel; fb_value_t val; logic tr; int kind;} row_t;
   // ------------------------------------------------
   // Stimulus table: kind 0 locked, 1 feedback fast, 2 feedback slow
   // ------------------------------------------------
   localparam int REF_RATIO [8] = '{8, 128, 256, 512, 1024, 2048, 2410, 8192};
   row_t rows [12] = '{
      '{3'h0, 14'h0008, 1'b1, 0}, '{3'h1, 14'h0080, 1'b1, 0}, '{3'h2, 14'h0100, 1'b1, 0},
      '{3'h3, 14'h0200, 1'b1, 0}, '{3'h4, 14'h00A8, 1'b0, 0}, '{3'h5, 14'h0800, 1'b1, 0},
      '{3'h6, 14'h096A, 1'b1, 0}, '{3'h7, 14'h2000, 1'b1, 0}, '{3'h0, 14'h0007, 1'b1, 1},
      '{3'h0, 14'h0009, 1'b1, 2}, '{3'h4, 14'h00A9, 1'b0, 2}, '{3'h0, 14'h0003, 1'b1, 1}};
   logic      clk, rst_b, run, tr, fb, osc, mon;
   ref_sel_t  sel;
   fb_value_t val;
   logic      pd, oe, ph_ref_b, ph_fb_b, fv, lock, fv_prev;
   logic      lock_lo, fb_only, ref_only, neg_seen, pos_seen, oe_seen, common;
   int        fv_rises, n_mismatch, check_count;

   vco_model i_vco (.clk_in(clk), .run_in(run), .wave_out(fb));
   vco_model i_osc (.clk_in(clk), .run_in(run), .wave_out(osc));
   pll_synth_core i_dut (
      .CLK_IN(clk), .RST_B_IN(rst_b), .FEEDBACK_IN(fb), .REF_OSC_INPUT_IN(osc),
      .REF_DIV_SELECT_IN(sel), .FEEDBACK_DIV_VALUE_IN(val), .TR_OFFSET_SELECT_IN(tr),
      .TRISTATE_PHASE_ERROR_OUT(pd), .TRISTATE_PHASE_ERROR_OE_OUT(oe),
      .PHASE_REF_B_OUT(ph_ref_b), .PHASE_FB_B_OUT(ph_fb_b),
      .FEEDBACK_DIV_OUT(fv), .LOCK_INDICATOR_OUT(lock));

   // ------------------------------------------------
   // Output monitor
   // ------------------------------------------------
   // Sticky flags sampled mid-cycle, well away from the launching edge
   always @(negedge clk) begin
      if (mon) begin
         if (lock === 1'b0) lock_lo = 1'b1;
         if (ph_fb_b === 1'b0 && ph_ref_b === 1'b1) fb_only = 1'b1;
         if (ph_ref_b === 1'b0 && ph_fb_b === 1'b1) ref_only = 1'b1;
         if (ph_ref_b === 1'b0 && ph_fb_b === 1'b0) common = 1'b1;
         if (oe === 1'b1 && pd === 1'b0) neg_seen = 1'b1;
         if (oe === 1'b1 && pd === 1'b1) pos_seen = 1'b1;
         if (oe === 1'b1) oe_seen = 1'b1;
         if (fv === 1'b1 && fv_prev === 1'b0) fv_rises++;
         fv_prev = fv;
      end
   end

   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   // Reset with idle levels checked while it is held; the first look is
   // one cycle in, before a standing error could have cleared by itself
   task automatic do_reset();
      rst_b <= 1'b0;
      @(negedge clk);
      `CHK(oe, 1'b0, "drive enable in reset")
      `CHK(lock, 1'b1, "lock level in reset")
      repeat (3) @(negedge clk);
      `CHK({ph_ref_b, ph_fb_b, fv}, 3'b110, "detector levels in reset")
      rst_b <= 1'b1;
      repeat (4) @(negedge clk);
   endtask

   // Both inputs run the same wave for 2*R+1 edges; only the ratios differ
   task automatic run_row(input row_t r);
      int edges;
      int rfb;
      edges = 2 * REF_RATIO[r.sel] + 1;
      rfb = int'(r.val) + (r.tr ? 0 : 856);
      sel <= r.sel;
      val <= r.val;
      tr <= r.tr;
      do_reset();
      {lock_lo, fb_only, ref_only, neg_seen, pos_seen, oe_seen, common} = '0;
      fv_rises = 0;
      fv_prev = 1'b0;
      mon = 1'b1;
      run <= 1'b1;
      repeat (2 * edges) @(negedge clk);
      run <= 1'b0;
      repeat (8) @(negedge clk);
      mon = 1'b0;
      `CHK(fb_only, logic'(r.kind == 1), "feedback-side error")
      `CHK(ref_only, logic'(r.kind == 2), "reference-side error")
      `CHK(neg_seen, logic'(r.kind == 1), "negative error pulse")
      `CHK(pos_seen, logic'(r.kind == 2), "positive error pulse")
      `CHK(oe_seen, logic'(r.kind != 0), "three-state drive")
      `CHK(lock_lo, logic'(r.kind != 0), "ratio table agreement")
      `CHK(lock_lo, oe_seen, "lock follows error")
      `CHK(common, 1'b1, "common minimum pulse")
      `CHK(fv_rises, (edges - 1) / rfb + 1, "divider output count")
      $display("Row sel %0d value %0d done", r.sel, r.val);
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ------------------------------------------------
   // Clock and main sequence
   // ------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      {rst_b, run, tr, mon, fv_prev} = 5'b00100;
      sel = 3'h0;
      val = 14'h0008;
      n_mismatch = 0;
      check_count = 0;
      do_reset();
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      // Reset in mid-run must drop a standing error at once; 36 cycles in,
      // the reference side has led since the 17th input edge
      sel <= 3'h0;
      val <= 14'h0009;
      tr  <= 1'b1;
      do_reset();
      run <= 1'b1;
      repeat (36) @(negedge clk);
      `CHK(oe, 1'b1, "error standing before reset")
      `CHK(lock, 1'b0, "lock low before reset")
      run <= 1'b0;
      do_reset();
      $display("Mid-run reset done");
      conclude();
   end
endmodule

/* File: testbench/vco_model.sv */
// Square-wave source standing in for the loop VCO and the reference oscillator
`timescale 1ns/1ps

module vco_model (
   // Clock and run control
   input  wire logic clk_in,
   input  wire logic run_in,
   // Oscillator output
   output logic      wave_out
);
   // ------------------------------------------------
   // Oscillator
   // ------------------------------------------------
   // Falling-edge toggle so the core samples settled levels; the wave
   // stands low between runs so two sources restart in phase
   always_ff @(negedge clk_in) begin
      if (!run_in) begin
         wave_out <= 1'b0;
      end else begin
         wave_out <= ~wave_out;
      end
   end
endmodule
